// File: design/ecr_bank.sv
// indexed bank of extended display and system control registers
// assumes the index/data port decode lies outside; shared-bit registers and host address state arrive as inputs
// Operation
// - 01xx10xx into first key unlocks extended set
// - 101xxxxx into second key unlocks system groups
// - strap bits writable only with key A5
// - system groups locked from reset until key
// - alternate refresh count overrides when enabled
// - top-of-memory selects 32K or 64K top area
// - high colour bit selects shifter width
// - read burst disable stops PCI read bursts only with the pci control enable set
// - fifo fetch start is nine bits
// - fifo fetch start active only when enabled
// - interlace offset sets even/odd start
// - interlace bit selects scan, enables offset
// - enhanced access bit gates x2E8 range
// - ready bit clear allows zero wait states
// - ready bit set forces one wait state
// - width bit 8 ignored unless extension 00
// - counter double doubles horizontal timing
// - cursor shown only enhanced and enabled
// - right storage uses tail of each line
`include "ecr_consts.svh"
`default_nettype none
module ecr_bank
    import ecr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_index,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_hit,
    input  wire logic        hsc_fifo_start_bit8,
    input  wire logic        bcr_fifo_enable,
    input  wire logic [1:0]  esc_width_ext,
    input  wire logic        pci_burst_allowed,
    input  wire logic        enhanced_mode,
    input  wire logic        pixel_8bpp,
    input  wire logic        host_addr13,
    input  wire logic        host_at_2e8,
    output logic             vga_ext_unlocked,
    output logic             sys_unlocked,
    output logic             strap_write_enable,
    output logic             refresh_override,
    output logic      [1:0]  refresh_count,
    output logic             top_mem_enable,
    output logic             top_mem_64k,
    output logic             shifter_8bit_mode,
    output logic             fast_text_font_write,
    output logic             pci_read_burst_enable,
    output logic             fifo_fetch_active,
    output logic      [8:0]  fifo_fetch_start,
    output logic             interlaced,
    output logic      [7:0]  interlace_offset,
    output logic             enhanced_access_grant,
    output logic             ready_min_one_wait,
    output logic             addr_latch_in_t1,
    output logic             logical_width_bit8,
    output logic             horizontal_double,
    output logic             cursor_visible,
    output logic             cursor_right_storage,
    output logic      [9:0]  cursor_line_bytes
);

    // one byte of storage per mapped index; reserved bits are kept at their fixed values
    logic [7:0] vga_key_r;
    logic [7:0] sys_key_r;
    logic [7:0] misc_r;
    logic [7:0] fifo_r;
    logic [7:0] il_r;
    logic [7:0] cfg_r;
    logic [7:0] flags_r;
    logic [7:0] scan_r;
    logic [7:0] ext_r;
    logic [7:0] cur_r;

    // each index belongs to one lock group; the vga group covers indices 3A to 3C
    function automatic ecr_grp_t grp_of(input logic [7:0] idx);
        unique case (idx)
            `ECR_IDX_VGA_KEY, `ECR_IDX_SYS_KEY:               grp_of = ECR_GRP_NONE;
            `ECR_IDX_MISC1, `ECR_IDX_FIFO_START, `ECR_IDX_IL_OFFSET: grp_of = ECR_GRP_VGA;
            default:                                          grp_of = ECR_GRP_SYS;
        endcase
    endfunction

    // only these ten indices answer; every other index reads as zero
    function automatic logic mapped(input logic [7:0] idx);
        unique case (idx)
            `ECR_IDX_VGA_KEY,
            `ECR_IDX_SYS_KEY,
            `ECR_IDX_MISC1,
            `ECR_IDX_FIFO_START,
            `ECR_IDX_IL_OFFSET,
            `ECR_IDX_SYS_CFG,
            `ECR_IDX_FW_FLAGS,
            `ECR_IDX_SCAN_MODE,
            `ECR_IDX_EXTENDED_MODE_CONTROL,
            `ECR_IDX_CURSOR_MODE: mapped = 1'b1;
            default:              mapped = 1'b0;
        endcase
    endfunction

    // unlock is decoded live from the key, so altering a significant bit relocks at once
    assign vga_ext_unlocked   = (vga_key_r & `ECR_VGA_KEY_MASK) == `ECR_VGA_KEY_VAL;
    assign sys_unlocked       = (sys_key_r & `ECR_SYS_KEY_MASK) == `ECR_SYS_KEY_VAL;
    assign strap_write_enable = sys_key_r == `ECR_STRAP_KEY;

    wire ecr_grp_t grp      = grp_of(reg_index);
    wire           is_map   = mapped(reg_index);
    wire           open_grp = (grp == ECR_GRP_NONE)
                           || (grp == ECR_GRP_VGA && vga_ext_unlocked)
                           || (grp == ECR_GRP_SYS && sys_unlocked);
    wire           wr_ok    = reg_wr && is_map && open_grp;
    wire           rd_ok    = reg_rd && is_map && open_grp;

    // reserved bits are held at their fixed values by masking on write
    wire [7:0] w_misc = reg_wdata & `ECR_MISC_WMASK;
    wire [7:0] w_cfg  = (reg_wdata & `ECR_CFG_WMASK) | (`ECR_RST_SYS_CFG & ~`ECR_CFG_WMASK);
    wire [7:0] w_scan = reg_wdata & `ECR_SCAN_WMASK;
    wire [7:0] w_ext  = reg_wdata & `ECR_EXT_WMASK;
    wire [7:0] w_cur  = reg_wdata & `ECR_CUR_WMASK;

    // one strobe per register, so each storage process stays a plain load
    wire       we_vga_key  = wr_ok && (reg_index == `ECR_IDX_VGA_KEY);
    wire       we_sys_key  = wr_ok && (reg_index == `ECR_IDX_SYS_KEY);
    wire       we_misc     = wr_ok && (reg_index == `ECR_IDX_MISC1);
    wire       we_fifo     = wr_ok && (reg_index == `ECR_IDX_FIFO_START);
    wire       we_il       = wr_ok && (reg_index == `ECR_IDX_IL_OFFSET);
    wire       we_cfg      = wr_ok && (reg_index == `ECR_IDX_SYS_CFG);
    wire       we_flags    = wr_ok && (reg_index == `ECR_IDX_FW_FLAGS);
    wire       we_scan     = wr_ok && (reg_index == `ECR_IDX_SCAN_MODE);
    wire       we_ext      = wr_ok && (reg_index == `ECR_IDX_EXTENDED_MODE_CONTROL);
    wire       we_cur      = wr_ok && (reg_index == `ECR_IDX_CURSOR_MODE);

    // a refused write keeps the old byte
    wire [7:0] vga_key_nxt = we_vga_key ? reg_wdata : vga_key_r;
    wire [7:0] sys_key_nxt = we_sys_key ? reg_wdata : sys_key_r;
    wire [7:0] misc_nxt    = we_misc    ? w_misc    : misc_r;
    wire [7:0] fifo_nxt    = we_fifo    ? reg_wdata : fifo_r;
    wire [7:0] il_nxt      = we_il      ? reg_wdata : il_r;
    wire [7:0] cfg_nxt     = we_cfg     ? w_cfg     : cfg_r;
    wire [7:0] flags_nxt   = we_flags   ? reg_wdata : flags_r;
    wire [7:0] scan_nxt    = we_scan    ? w_scan    : scan_r;
    wire [7:0] ext_nxt     = we_ext     ? w_ext     : ext_r;
    wire [7:0] cur_nxt     = we_cur     ? w_cur     : cur_r;

    // storage: power-on values under reset, otherwise the next value
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vga_key_r <= `ECR_RST_ZERO;
        end
        else
        begin
            vga_key_r <= vga_key_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sys_key_r <= `ECR_RST_ZERO;
        end
        else
        begin
            sys_key_r <= sys_key_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            misc_r <= `ECR_RST_ZERO;
        end
        else
        begin
            misc_r <= misc_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fifo_r <= `ECR_RST_ZERO;
        end
        else
        begin
            fifo_r <= fifo_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            il_r <= `ECR_RST_ZERO;
        end
        else
        begin
            il_r <= il_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_r <= `ECR_RST_SYS_CFG;
        end
        else
        begin
            cfg_r <= cfg_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_r <= `ECR_RST_ZERO;
        end
        else
        begin
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scan_r <= `ECR_RST_ZERO;
        end
        else
        begin
            scan_r <= scan_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_r <= `ECR_RST_ZERO;
        end
        else
        begin
            ext_r <= ext_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur_r <= `ECR_RST_ZERO;
        end
        else
        begin
            cur_r <= cur_nxt;
        end
    end

    logic [7:0] rd_mux;
    always_comb
    begin
        unique case (reg_index)
            `ECR_IDX_VGA_KEY:     rd_mux = vga_key_r;
            `ECR_IDX_SYS_KEY:     rd_mux = sys_key_r;
            `ECR_IDX_MISC1:       rd_mux = misc_r;
            `ECR_IDX_FIFO_START:  rd_mux = fifo_r;
            `ECR_IDX_IL_OFFSET:   rd_mux = il_r;
            `ECR_IDX_SYS_CFG:     rd_mux = cfg_r;
            `ECR_IDX_FW_FLAGS:    rd_mux = flags_r;
            `ECR_IDX_SCAN_MODE:   rd_mux = scan_r;
            `ECR_IDX_EXTENDED_MODE_CONTROL:    rd_mux = ext_r;
            `ECR_IDX_CURSOR_MODE: rd_mux = cur_r;
            default:              rd_mux = `ECR_RST_ZERO;
        endcase
    end

    // read data is registered: valid the cycle after reg_rd; locked reads return zero
    wire [7:0] rdata_nxt = rd_ok ? rd_mux : `ECR_RST_ZERO;
    wire       hit_nxt   = rd_ok;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= `ECR_RST_ZERO;
        end
        else
        begin
            reg_rdata <= rdata_nxt;
        end
    end

    // hit tells a zero byte that was read from a refused read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_hit <= 1'b0;
        end
        else
        begin
            reg_hit <= hit_nxt;
        end
    end

    assign refresh_override      = misc_r[`ECR_MISC_RFC];
    assign refresh_count         = misc_r[`ECR_MISC_CNT_LSB+1:`ECR_MISC_CNT_LSB];
    assign top_mem_enable        = misc_r[`ECR_MISC_TOPMEM];
    assign top_mem_64k           = misc_r[`ECR_MISC_TOPMEM] & host_addr13;
    assign shifter_8bit_mode     = misc_r[`ECR_MISC_HICOL];
    assign fast_text_font_write  = misc_r[`ECR_MISC_FASTFONT];
    // the pci control enable gates the disable bit as a live level, in either order; without it the disable bit has no effect
    assign pci_read_burst_enable = !(misc_r[`ECR_MISC_RBDIS] & pci_burst_allowed);
    assign fifo_fetch_active     = bcr_fifo_enable;
    assign fifo_fetch_start      = bcr_fifo_enable ? {hsc_fifo_start_bit8, fifo_r} : 9'h000;
    assign interlaced            = scan_r[`ECR_SCAN_IL];
    assign interlace_offset      = scan_r[`ECR_SCAN_IL] ? il_r : 8'h00;
    assign enhanced_access_grant = cfg_r[`ECR_CFG_ENH] & host_at_2e8;
    assign ready_min_one_wait    = cfg_r[`ECR_CFG_RDY];
    assign addr_latch_in_t1      = !cfg_r[`ECR_CFG_RDY];
    assign logical_width_bit8    = ext_r[`ECR_EXT_LSW8] & (esc_width_ext == 2'b00);
    assign horizontal_double     = ext_r[`ECR_EXT_HDBL];
    assign cursor_visible        = cur_r[`ECR_CUR_EN] & enhanced_mode;
    assign cursor_right_storage  = cur_r[`ECR_CUR_RIGHT];
    // bytes of each line given to the cursor when right storage is on
    assign cursor_line_bytes     = !cur_r[`ECR_CUR_RIGHT] ? 10'h000
                                 : (pixel_8bpp ? 10'h200 : 10'h100);

endmodule
`default_nettype wire

// File: design/ecr_consts.svh
// index offsets, field positions, reset values and keys of the extended control bank
// assumes inclusion by the bank module only
`ifndef ECR_CONSTS_SVH
`define ECR_CONSTS_SVH

`define ECR_IDX_VGA_KEY      8'h38
`define ECR_IDX_SYS_KEY      8'h39
`define ECR_IDX_MISC1        8'h3A
`define ECR_IDX_FIFO_START   8'h3B
`define ECR_IDX_IL_OFFSET    8'h3C
`define ECR_IDX_SYS_CFG      8'h40
`define ECR_IDX_FW_FLAGS     8'h41
`define ECR_IDX_SCAN_MODE    8'h42
`define ECR_IDX_EXTENDED_MODE_CONTROL     8'h43
`define ECR_IDX_CURSOR_MODE  8'h45

`define ECR_RST_ZERO         8'h00
`define ECR_RST_SYS_CFG      8'h30

`define ECR_VGA_KEY_MASK     8'hCC
`define ECR_VGA_KEY_VAL      8'h48
`define ECR_SYS_KEY_MASK     8'hE0
`define ECR_SYS_KEY_VAL      8'hA0
`define ECR_STRAP_KEY        8'hA5

`define ECR_CFG_WMASK        8'h11
`define ECR_SCAN_WMASK       8'h20
`define ECR_EXT_WMASK        8'h84
`define ECR_CUR_WMASK        8'h11
`define ECR_MISC_WMASK       8'hBF

`define ECR_MISC_CNT_LSB     0
`define ECR_MISC_RFC         2
`define ECR_MISC_TOPMEM      3
`define ECR_MISC_HICOL       4
`define ECR_MISC_FASTFONT    5
`define ECR_MISC_RBDIS       7
`define ECR_CFG_ENH          0
`define ECR_CFG_RDY          4
`define ECR_SCAN_IL          5
`define ECR_EXT_LSW8         2
`define ECR_EXT_HDBL         7
`define ECR_CUR_EN           0
`define ECR_CUR_RIGHT        4
`define ECR_ADDR_TOP_BIT     13

`endif

// File: design/ecr_pkg.sv
// types for the extended control bank
// assumes nothing outside itself
`default_nettype none
package ecr_pkg;
    typedef enum logic [1:0] {ECR_GRP_VGA, ECR_GRP_SYS, ECR_GRP_NONE} ecr_grp_t;
endpackage
`default_nettype wire

// File: dv/ecr_bank_monitor.sv
// concurrent checks on the extended control bank ports
// assumes a single clock domain and binding onto every bank instance
`default_nettype none
module ecr_bank_monitor (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] reg_index,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_hit,
    input wire logic       vga_ext_unlocked,
    input wire logic       sys_unlocked,
    input wire logic       strap_write_enable,
    input wire logic       bcr_fifo_enable,
    input wire logic [8:0] fifo_fetch_start,
    input wire logic       interlaced,
    input wire logic [7:0] interlace_offset,
    input wire logic       ready_min_one_wait,
    input wire logic       addr_latch_in_t1,
    input wire logic [1:0] esc_width_ext,
    input wire logic       logical_width_bit8,
    input wire logic       enhanced_mode,
    input wire logic       cursor_visible
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_key1; reg_wr && reg_index == 8'h38; endsequence
    sequence s_key2; reg_wr && reg_index == 8'h39; endsequence
    property p_vga; s_key1 |=> vga_ext_unlocked == (($past(reg_wdata) & 8'hCC) == 8'h48);
    endproperty
    a_vga: assert property (p_vga) else $error("first key decode wrong");
    property p_sys; s_key2 |=> sys_unlocked == (($past(reg_wdata) & 8'hE0) == 8'hA0); endproperty
    a_sys: assert property (p_sys) else $error("second key decode wrong");
    property p_strap; s_key2 |=> strap_write_enable == ($past(reg_wdata) == 8'hA5); endproperty
    a_strap: assert property (p_strap) else $error("strap enable wrong");
    // a locked read must not leak the stored byte
    property p_lock; reg_rd && reg_index == 8'h40 && !sys_unlocked
        |=> !reg_hit && reg_rdata == 8'h00;
    endproperty
    a_lock: assert property (p_lock) else $error("locked read answered");
    property p_fifo; !bcr_fifo_enable |-> fifo_fetch_start == 9'h000; endproperty
    a_fifo: assert property (p_fifo) else $error("fetch start active while disabled");
    property p_il; !interlaced |-> interlace_offset == 8'h00; endproperty
    a_il: assert property (p_il) else $error("offset without interlace");
    property p_rdy; !ready_min_one_wait |-> addr_latch_in_t1; endproperty
    a_rdy: assert property (p_rdy) else $error("zero wait without t1 latch");
    property p_lsw; esc_width_ext != 2'b00 |-> !logical_width_bit8; endproperty
    a_lsw: assert property (p_lsw) else $error("width bit 8 not ignored");
    property p_cur; cursor_visible |-> enhanced_mode; endproperty
    a_cur: assert property (p_cur) else $error("cursor outside enhanced mode");
endmodule
bind ecr_bank ecr_bank_monitor u_ecr_bank_monitor (.*);
`default_nettype wire

// File: dv/ecr_host_model.sv
// host-side levels seen by the bank: shared bits of other registers and host address state
// assumes the bench packs them into one knob vector, driven on the rising clock edge
`default_nettype none
module ecr_host_model (
    input  wire logic [8:0] knob,
    output logic            hsc_fifo_start_bit8,
    output logic            bcr_fifo_enable,
    output logic      [1:0] esc_width_ext,
    output logic            pci_burst_allowed,
    output logic            enhanced_mode,
    output logic            pixel_8bpp,
    output logic            host_addr13,
    output logic            host_at_2e8
);
    timeunit 1ns;
    timeprecision 1ps;
    // pci control bit stays set before burst disable is written, so it is held as a level
    assign {host_at_2e8, host_addr13, pixel_8bpp, enhanced_mode, pci_burst_allowed,
            esc_width_ext, bcr_fifo_enable, hsc_fifo_start_bit8} = knob;
endmodule
`default_nettype wire

// File: dv/tb_ecr_bank.sv
// self-checking bench for the extended control bank
// assumes host levels come from the host model; no strap registers are modelled
`default_nettype none
module tb_ecr_bank;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, reg_hit, vga_ext_unlocked, sys_unlocked;
    logic strap_write_enable, refresh_override, top_mem_enable, top_mem_64k, shifter_8bit_mode;
    logic fast_text_font_write, pci_read_burst_enable, fifo_fetch_active, interlaced;
    logic enhanced_access_grant, ready_min_one_wait, addr_latch_in_t1, logical_width_bit8;
    logic horizontal_double, cursor_visible, cursor_right_storage, hsc_fifo_start_bit8;
    logic bcr_fifo_enable, pci_burst_allowed, enhanced_mode, pixel_8bpp, host_addr13, host_at_2e8;
    logic [7:0] reg_index = 0, reg_wdata = 0, reg_rdata, interlace_offset;
    logic [1:0] refresh_count, esc_width_ext;
    logic [8:0] fifo_fetch_start, knob = 9'h1F3;
    logic [9:0] cursor_line_bytes;
    int n_errors = 0, tests_run = 0;
    ecr_bank u_ecr_bank (.*);
    ecr_host_model u_ecr_host_model (.*);
    initial forever #10 clk = ~clk;
    task automatic chk(input logic [23:0] s, input logic [23:0] e);
        tests_run++;
        if (s !== e)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge clk);
        reg_index <= i; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // read data stands for one cycle only, so it is sampled just after the taking edge
    task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic h);
        @(posedge clk);
        reg_index <= i; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
        chk(reg_hit, h);
    endtask
    task automatic stop_test;
        if (n_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (1000) @(posedge clk);
        n_errors++;
        stop_test;
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h40, 8'h00, 1'b0);
        rd(8'h38, 8'h00, 1'b1);
        wr(8'h40, 8'h01);
        wr(8'h39, 8'hBF);
        chk({sys_unlocked, strap_write_enable}, 2'b10);
        rd(8'h40, 8'h30, 1'b1);
        wr(8'h40, 8'h01);
        rd(8'h40, 8'h21, 1'b1);
        chk({ready_min_one_wait, addr_latch_in_t1, enhanced_access_grant}, 3'b011);
        wr(8'h40, 8'h10);
        chk({ready_min_one_wait, enhanced_access_grant}, 2'b10);
        wr(8'h39, 8'hA5);
        chk({sys_unlocked, strap_write_enable}, 2'b11);
        wr(8'h39, 8'hE0);
        chk(sys_unlocked, 1'b0);
        wr(8'h3A, 8'hFF);
        rd(8'h3A, 8'h00, 1'b0);
        wr(8'h38, 8'h7B);
        chk(vga_ext_unlocked, 1'b1);
        wr(8'h3A, 8'hFF);
        rd(8'h3A, 8'hBF, 1'b1);
        chk({refresh_override, refresh_count, top_mem_enable, top_mem_64k, shifter_8bit_mode,
             fast_text_font_write, pci_read_burst_enable}, 8'hFE);
        wr(8'h3A, 8'h01);
        chk({refresh_override, top_mem_enable, shifter_8bit_mode, pci_read_burst_enable}, 4'h1);
        wr(8'h3B, 8'hA5);
        chk({fifo_fetch_active, fifo_fetch_start}, 10'h3A5);
        wr(8'h3C, 8'h5A);
        chk(interlace_offset, 8'h00);
        wr(8'h39, 8'hA0);
        wr(8'h42, 8'h20);
        chk({interlaced, interlace_offset}, 9'h15A);
        wr(8'h43, 8'h84);
        chk({horizontal_double, logical_width_bit8}, 2'b11);
        wr(8'h45, 8'h11);
        chk({cursor_visible, cursor_right_storage, cursor_line_bytes}, 12'hE00);
        rd(8'h44, 8'h00, 1'b0);
        @(posedge clk);
        knob <= 9'h015;
        @(posedge clk);
        #1;
        chk({cursor_visible, logical_width_bit8, fifo_fetch_active}, 3'b000);
        chk({cursor_line_bytes, fifo_fetch_start}, 19'h20000);
        stop_test;
    end
endmodule
`default_nettype wire
